// *** hdl/scwc_defs.svh ***
// Constants for the storage card write command engine.
// Assumes inclusion by the package and the engine only.
`ifndef SCWC_DEFS_SVH
`define SCWC_DEFS_SVH
// ****************************************
// Register offsets (word addresses on wb_adr_i)
// ****************************************
`define SCWC_OFF_CMD      4'h0
`define SCWC_OFF_SECCNT   4'h1
`define SCWC_OFF_SECNUM   4'h2
`define SCWC_OFF_CYLLO    4'h3
`define SCWC_OFF_CYLHI    4'h4
`define SCWC_OFF_HEAD     4'h5
`define SCWC_OFF_STATUS   4'h6
`define SCWC_OFF_CONFIG   4'h7
`define SCWC_OFF_ERROR    4'h8
`define SCWC_OFF_MEDIA    4'h9
// ****************************************
// Command codes
// ****************************************
`define SCWC_CMD_DMA      8'hca
`define SCWC_CMD_MULT     8'hc5
`define SCWC_CMD_MULT_NE  8'hcd
// ****************************************
// Field positions
// ****************************************
`define SCWC_ST_BUSY      7
`define SCWC_ST_ERR       0
`define SCWC_ST_DRQ       3
`define SCWC_ST_IRQ       1
`define SCWC_ST_NOERASE   2
`define SCWC_CFG_8BIT     0
`define SCWC_CFG_MULT_SET 1
`define SCWC_CFG_MULT_DIS 2
`define SCWC_CFG_LBA      3
`define SCWC_ERR_ABRT     8'h04
`define SCWC_ERR_WRITE    8'h40
`define SCWC_MEDIA_DONE   0
`define SCWC_MEDIA_FAIL   1
// ****************************************
// Sizes and timing
// ****************************************
`define SCWC_WORDS_PER_SEC 9'd256
`define SCWC_MAX_SECTORS   9'd256
`define SCWC_BLOCK_SECTORS 9'd1
`define SCWC_CLK_HZ        25000000
`define SCWC_BUSY_MAX_NS   400
`define SCWC_BUSY_CYC      ((`SCWC_BUSY_MAX_NS * (`SCWC_CLK_HZ / 1000000)) / 1000)
`endif

// *** hdl/scwc_engine.sv ***
// Write command engine of a flash storage card: DMA write and multiple write.
// Assumes a classic Wishbone master for the task file and host DMA pins from another domain.
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "scwc_defs.svh"
module scwc_engine
  import scwc_pkg::*;
#(
  parameter int unsigned BLOCK_SECTORS = 1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        dma_acknowledge_n_i,
  input  wire logic        io_write_strobe_n_i,
  input  wire logic [15:0] host_data_i,
  output logic             dma_request_line_o,
  output logic             device_busy_flag_o,
  output logic             data_request_flag_o,
  output logic             intrq_o,
  output logic             media_wr_valid_o,
  output logic      [15:0] media_wr_data_o,
  output logic      [27:0] media_lba_o,
  output logic             media_commit_o,
  output logic             media_no_erase_o,
  input  wire logic        media_done_i,
  input  wire logic        media_fail_i,
  output logic       [8:0] block_size_o
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [27:0] lba_of(input scwc_addr_t a);
    return {a.head, a.cylhi, a.cyllo, a.secnum};
  endfunction

  function automatic scwc_addr_t addr_inc(input scwc_addr_t a);
    logic [27:0] v;
    v = lba_of(a) + 28'd1;
    return '{secnum: v[7:0], cyllo: v[15:8], cylhi: v[23:16], head: v[27:24]};
  endfunction

  scwc_state_bundle_t s_q;
  scwc_state_bundle_t s_d;
  logic               wr_acc;
  logic               rd_acc;
  logic               word_stb;
  logic               last_word;
  logic [8:0]         count_req;
  logic [31:0]        status_w;

  // ****************************************
  // Bus decode and pin sampling
  // ****************************************
  assign wr_acc    = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack && wb_sel_i[0];
  assign rd_acc    = wb_cyc_i && wb_stb_i && !wb_we_i && !s_q.ack;
  assign word_stb  = (!s_q.is_dma || (s_q.dma_request_line && !s_q.ack_s[1])) && s_q.iow_prev && !s_q.iow_s[1];
  assign last_word = (s_q.word_cnt == 8'hff);
  assign count_req = (s_q.seccnt == 8'h00) ? `SCWC_MAX_SECTORS : {1'b0, s_q.seccnt};
  assign status_w  = {24'h0, s_q.busy, 3'b000, s_q.data_request_flag, s_q.no_erase, s_q.irq, s_q.err};

  always_comb begin
    s_d          = s_q;
    s_d.ack      = wb_cyc_i && wb_stb_i && !s_q.ack;
    s_d.ack_s    = {s_q.ack_s[0], dma_acknowledge_n_i};
    s_d.iow_s    = {s_q.iow_s[0], io_write_strobe_n_i};
    s_d.iow_prev = s_q.iow_s[1];
    s_d.dat_s    = {s_q.dat_s[15:0], host_data_i};
    s_d.wr_vld   = 1'b0;
    s_d.commit   = 1'b0;
    if (rd_acc) begin
      unique case (wb_adr_i)
        `SCWC_OFF_CMD:    s_d.rdat = 32'h0;
        `SCWC_OFF_SECCNT: s_d.rdat = {24'h0, s_q.seccnt};
        `SCWC_OFF_SECNUM: s_d.rdat = {24'h0, s_q.addr.secnum};
        `SCWC_OFF_CYLLO:  s_d.rdat = {24'h0, s_q.addr.cyllo};
        `SCWC_OFF_CYLHI:  s_d.rdat = {24'h0, s_q.addr.cylhi};
        `SCWC_OFF_HEAD:   s_d.rdat = {24'h0, 1'b1, s_q.lba, 2'b10, s_q.addr.head};
        `SCWC_OFF_STATUS: s_d.rdat = status_w;
        `SCWC_OFF_CONFIG: s_d.rdat = {28'h0, s_q.lba, s_q.mult_dis, s_q.mult_set, s_q.mode_8bit};
        `SCWC_OFF_ERROR:  s_d.rdat = {24'h0, s_q.error};
        default:          s_d.rdat = 32'h0;
      endcase
      if (wb_adr_i == `SCWC_OFF_STATUS) begin
        s_d.irq = 1'b0;
      end
    end
    // Task file writes are ignored while a command runs.
    if (wr_acc && s_q.state == SCWC_IDLE) begin
      unique case (wb_adr_i)
        `SCWC_OFF_SECCNT: s_d.seccnt = wb_dat_i[7:0];
        `SCWC_OFF_SECNUM: s_d.addr.secnum = wb_dat_i[7:0];
        `SCWC_OFF_CYLLO:  s_d.addr.cyllo = wb_dat_i[7:0];
        `SCWC_OFF_CYLHI:  s_d.addr.cylhi = wb_dat_i[7:0];
        `SCWC_OFF_HEAD: begin
          s_d.addr.head = wb_dat_i[3:0];
          s_d.lba       = wb_dat_i[6];
        end
        `SCWC_OFF_CONFIG: begin
          s_d.mode_8bit = wb_dat_i[`SCWC_CFG_8BIT];
          s_d.mult_set  = wb_dat_i[`SCWC_CFG_MULT_SET];
          s_d.mult_dis  = wb_dat_i[`SCWC_CFG_MULT_DIS];
        end
        `SCWC_OFF_CMD: begin
          s_d.err   = 1'b0;
          s_d.error = 8'h00;
          s_d.irq   = 1'b0;
          if (wb_dat_i[7:0] == `SCWC_CMD_DMA) begin
            if (s_q.mode_8bit) begin
              s_d.err   = 1'b1;
              s_d.error = `SCWC_ERR_ABRT;
              s_d.irq   = 1'b1;
            end else begin
              s_d.is_dma   = 1'b1;
              s_d.no_erase = 1'b0;
              s_d.remain   = count_req;
              s_d.busy     = 1'b1;
              s_d.state    = SCWC_BUSY;
            end
          end else if (wb_dat_i[7:0] == `SCWC_CMD_MULT || wb_dat_i[7:0] == `SCWC_CMD_MULT_NE) begin
            if (!s_q.mult_set || s_q.mult_dis) begin
              s_d.err   = 1'b1;
              s_d.error = `SCWC_ERR_ABRT;
              s_d.irq   = 1'b1;
            end else begin
              s_d.is_dma   = 1'b0;
              s_d.no_erase = (wb_dat_i[7:0] == `SCWC_CMD_MULT_NE);
              s_d.remain   = count_req;
              s_d.busy     = 1'b1;
              s_d.state    = SCWC_BUSY;
            end
          end else begin
            s_d.err   = 1'b1;
            s_d.error = `SCWC_ERR_ABRT;
            s_d.irq   = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // ****************************************
    // Command sequencing
    // ****************************************
    unique case (s_q.state)
      SCWC_IDLE: begin
      end
      SCWC_BUSY: begin
        // Buffer ready: open the next block or sector for data.
        s_d.busy     = 1'b0;
        s_d.data_request_flag      = 1'b1;
        s_d.word_cnt = 8'h00;
        s_d.blk_left = (s_q.remain < 9'(BLOCK_SECTORS)) ? s_q.remain : 9'(BLOCK_SECTORS);
        s_d.dma_request_line   = s_q.is_dma;
        if (!s_q.is_dma && s_q.remain != count_req) begin
          s_d.irq = 1'b1;
        end
        s_d.state = SCWC_XFER;
      end
      SCWC_XFER: begin
        if (word_stb) begin
          s_d.wr_vld   = 1'b1;
          s_d.wr_dat   = s_q.dat_s[31:16];
          s_d.word_cnt = s_q.word_cnt + 8'h01;
          if (last_word) begin
            s_d.commit = 1'b1;
            s_d.dma_request_line = 1'b0;
            s_d.busy   = 1'b1;
            s_d.data_request_flag    = 1'b0;
            s_d.state  = SCWC_FLUSH;
          end
        end
      end
      SCWC_FLUSH: begin
        if (media_fail_i) begin
          s_d.err    = 1'b1;
          s_d.error  = `SCWC_ERR_WRITE;
          s_d.busy   = 1'b0;
          s_d.irq    = 1'b1;
          s_d.seccnt = s_q.remain[7:0];
          s_d.state  = SCWC_IDLE;
        end else if (media_done_i) begin
          s_d.remain   = s_q.remain - 9'd1;
          s_d.blk_left = s_q.blk_left - 9'd1;
          if (s_q.remain == 9'd1) begin
            s_d.state = SCWC_DONE;
          end else begin
            s_d.addr  = addr_inc(s_q.addr);
            s_d.state = (s_q.blk_left == 9'd1) ? SCWC_BUSY : SCWC_XFER;
            if (s_q.blk_left != 9'd1) begin
              s_d.busy     = 1'b0;
              s_d.word_cnt = 8'h00;
              s_d.dma_request_line   = s_q.is_dma;
            end
          end
        end
      end
      SCWC_DONE: begin
        s_d.busy   = 1'b0;
        s_d.irq    = 1'b1;
        s_d.seccnt = 8'h00;
        s_d.state  = SCWC_IDLE;
      end
      default: s_d.state = SCWC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q          <= '0;
      s_q.ack_s    <= 2'b11;
      s_q.iow_s    <= 2'b11;
      s_q.iow_prev <= 1'b1;
      s_q.seccnt   <= 8'h01;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wb_ack_o            = s_q.ack;
  assign wb_dat_o            = s_q.rdat;
  assign dma_request_line_o  = s_q.dma_request_line;
  assign device_busy_flag_o  = s_q.busy;
  assign data_request_flag_o = s_q.data_request_flag;
  assign intrq_o             = s_q.irq;
  assign media_wr_valid_o    = s_q.wr_vld;
  assign media_wr_data_o     = s_q.wr_dat;
  assign media_lba_o         = lba_of(s_q.addr);
  assign media_commit_o      = s_q.commit;
  assign media_no_erase_o    = s_q.no_erase;
  assign block_size_o        = 9'(BLOCK_SECTORS);

endmodule

// *** hdl/scwc_pkg.sv ***
// Types for the storage card write command engine.
// Assumes scwc_defs.svh is on the include path.
`include "scwc_defs.svh"
package scwc_pkg;
  typedef enum logic [2:0] {
    SCWC_IDLE  = 3'b000,
    SCWC_BUSY  = 3'b001,
    SCWC_XFER  = 3'b010,
    SCWC_FLUSH = 3'b011,
    SCWC_DONE  = 3'b100
  } scwc_state_t;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } scwc_wb_req_t;

  typedef struct packed {
    logic [7:0] secnum;
    logic [7:0] cyllo;
    logic [7:0] cylhi;
    logic [3:0] head;
  } scwc_addr_t;

  typedef struct packed {
    scwc_state_t state;
    logic        is_dma;
    logic        no_erase;
    scwc_addr_t  addr;
    logic [8:0]  remain;
    logic [8:0]  blk_left;
    logic [7:0]  word_cnt;
    logic [7:0]  seccnt;
    logic        busy;
    logic        data_request_flag;
    logic        err;
    logic        irq;
    logic        lba;
    logic        mode_8bit;
    logic        mult_set;
    logic        mult_dis;
    logic [7:0]  error;
    logic        ack;
    logic [31:0] rdat;
    logic        dma_request_line;
    logic        wr_vld;
    logic [15:0] wr_dat;
    logic        commit;
    logic [1:0]  ack_s;
    logic [1:0]  iow_s;
    logic        iow_prev;
    logic [31:0] dat_s;
  } scwc_state_bundle_t;
endpackage

// *** tb/scwc_host_model.sv ***
// Host model: word strobes on the DMA and data pins, plus a media backend.
// Assumes the engine's clock; the bench sets pace and failure.
`timescale 1ns/1ps
module scwc_host_model (
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  input  wire logic        fail_i,
  input  wire logic        dma_request_line_i,
  input  wire logic        data_request_flag_i,
  input  wire logic        media_commit_i,
  output logic             dma_acknowledge_n_o,
  output logic             io_write_strobe_n_o,
  output logic      [15:0] host_data_o,
  output logic             media_done_o,
  output logic             media_fail_o
);
  logic [15:0] w_q = 16'h0000;
  logic [4:0]  d_q = 5'd0;
  // **********
  // Host words
  // **********
  initial begin
    dma_acknowledge_n_o = 1'b1;
    io_write_strobe_n_o = 1'b1;
    host_data_o         = 16'hffff;
    forever begin
      @(posedge clk_i);
      if (dma_request_line_i || data_request_flag_i) begin
        dma_acknowledge_n_o <= !dma_request_line_i;
        host_data_o         <= 16'h5a00 ^ w_q;
        io_write_strobe_n_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        io_write_strobe_n_o <= 1'b1;
        w_q = w_q + 16'h0001;
        repeat (slow_i ? 8 : 3) @(posedge clk_i);
        host_data_o <= ~host_data_o;
      end else begin
        dma_acknowledge_n_o <= 1'b1;
      end
    end
  end
  always @(posedge clk_i) begin
    if (media_commit_i) d_q <= slow_i ? 5'd20 : 5'd3;
    else if (d_q != 5'd0) d_q <= d_q - 5'd1;
  end
  assign media_done_o = d_q == 5'd1 && !fail_i;
  assign media_fail_o = d_q == 5'd1 && fail_i;
endmodule

// *** tb/scwc_props.sv ***
// Checker for the write command engine ports.
// Assumes a bind onto scwc_engine.
`timescale 1ns/1ps
module scwc_props
  import scwc_pkg::*;
#(
  parameter int unsigned BLOCK_SECTORS = 1
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        dma_request_line_o,
  input wire logic        device_busy_flag_o,
  input wire logic        data_request_flag_o,
  input wire logic        intrq_o,
  input wire logic        media_wr_valid_o,
  input wire logic        media_commit_o,
  input wire logic        media_no_erase_o
);
  logic [7:0] cmd_q;
  logic       first_q;
  logic [8:0] wcnt_q;
  logic       take;
  assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 4'h0
                && !device_busy_flag_o && !data_request_flag_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q   <= 8'h00;
      first_q <= 1'b0;
      wcnt_q  <= 9'h000;
    end else begin
      cmd_q   <= take ? wb_dat_i[7:0] : cmd_q;
      first_q <= take || (first_q && !media_commit_o);
      wcnt_q  <= media_commit_o ? 9'h000 : wcnt_q + 9'(media_wr_valid_o);
    end
  end
  // **********
  // Assertions
  // **********
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_busy_fast: assert property (take && (wb_dat_i[7:0] & 8'hf7) == 8'hc5
    |-> ##[1:10] (device_busy_flag_o || intrq_o)) else $error("busy late");
  a_drq_after_busy: assert property ($rose(data_request_flag_o)
    |-> $past(device_busy_flag_o) && !device_busy_flag_o) else $error("drq order");
  a_first_quiet: assert property (first_q && $rose(data_request_flag_o) |-> !intrq_o)
    else $error("early irq");
  a_dma_request_line_open: assert property (dma_request_line_o |-> data_request_flag_o && cmd_q == 8'hca)
    else $error("dma_request_line");
  a_dma_irq_end: assert property (cmd_q == 8'hca && $rose(intrq_o)
    |-> !dma_request_line_o && !device_busy_flag_o) else $error("dma irq");
  a_blk_irq: assert property (cmd_q != 8'hca && !first_q && $rose(data_request_flag_o) |-> intrq_o)
    else $error("block irq");
  a_sector_words: assert property (media_commit_o |-> wcnt_q + 9'(media_wr_valid_o) == 9'd256)
    else $error("word count");
  a_commit_busy: assert property (media_commit_o
    |-> device_busy_flag_o && !data_request_flag_o && !dma_request_line_o) else $error("commit");
  a_no_erase: assert property (media_wr_valid_o |-> media_no_erase_o == (cmd_q == 8'hcd))
    else $error("erase mode");
  c_dma_end: cover property (cmd_q == 8'hca && $rose(intrq_o));
  c_blk: cover property (!first_q && $rose(data_request_flag_o));
  c_commit: cover property (media_commit_o);
endmodule
bind scwc_engine scwc_props #(.BLOCK_SECTORS(BLOCK_SECTORS)) u_props (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o,
  .dma_request_line_o, .device_busy_flag_o, .data_request_flag_o, .intrq_o,
  .media_wr_valid_o, .media_commit_o, .media_no_erase_o);

// *** tb/storage_card_write_commands_tb.sv ***
// Self-checking bench for the write command engine.
// Assumes scwc_props and scwc_host_model are compiled first.
`timescale 1ns/1ps
module storage_card_write_commands_tb;
  import scwc_pkg::*;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         slow_q = 1'b0;
  logic         fail_q = 1'b0;
  scwc_wb_req_t wb = '0;
  logic [31:0]  wb_dat_o;
  logic [15:0]  hdata, wr_dat;
  logic [27:0]  lba;
  logic [7:0]   q;
  logic [8:0]   bsz;
  logic         wb_ack_o, ack_n, iow_n, dma_request_line, busy, data_request_flag, intrq_o, wr_vld, commit, no_erase, done, fail;
  int           err_total = 0;
  int           compares = 0;
  initial forever #20 clk_i = ~clk_i;
  scwc_engine #(.BLOCK_SECTORS(1)) u_dut (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i(wb.cyc),
    .wb_stb_i(wb.stb), .wb_we_i(wb.we), .wb_adr_i(wb.adr), .wb_sel_i(wb.sel), .wb_dat_i(wb.dat),
    .wb_dat_o, .wb_ack_o, .dma_acknowledge_n_i(ack_n), .io_write_strobe_n_i(iow_n),
    .host_data_i(hdata), .dma_request_line_o(dma_request_line), .device_busy_flag_o(busy),
    .data_request_flag_o(data_request_flag), .intrq_o, .media_wr_valid_o(wr_vld), .media_wr_data_o(wr_dat),
    .media_lba_o(lba), .media_commit_o(commit), .media_no_erase_o(no_erase),
    .media_done_i(done), .media_fail_i(fail), .block_size_o(bsz));
  scwc_host_model u_host (.clk_i, .slow_i(slow_q), .fail_i(fail_q), .dma_request_line_i(dma_request_line),
    .data_request_flag_i(data_request_flag), .media_commit_i(commit), .dma_acknowledge_n_o(ack_n),
    .io_write_strobe_n_o(iow_n), .host_data_o(hdata), .media_done_o(done), .media_fail_o(fail));
  // *****
  // Tasks
  // *****
  task automatic close_out();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1, dat: {24'h0, d}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    chk("ack", 32'h1, 32'(n < 50));
    q = wb_dat_o[7:0];
    wb <= '0;
  endtask
  task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, e, q & m);
  endtask
  task automatic load(input logic [7:0] cfg, input logic [7:0] cnt, input logic [7:0] sn,
                      input logic [7:0] cmd);
    logic [7:0] v [7];
    v = '{cfg, cnt, sn, 8'h34, 8'h12, 8'h43, cmd};
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, i == 0 ? 4'h7 : 4'(i % 6), v[i]);
    end
  endtask
  task automatic wait_end();
    int n;
    n = 0;
    while (!(intrq_o === 1'b1 && busy === 1'b0 && data_request_flag === 1'b0) && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    chk("finish", 32'h1, 32'(n < 20000));
  endtask
  task automatic t_reset();
    chk("idle pins", 32'h0, {busy, data_request_flag, intrq_o, dma_request_line});
    chk("block size", 32'h1, {23'h0, bsz});
    rd("count", 4'h1, 8'hff, 8'h01);
    rd("unmapped", 4'hf, 8'hff, 8'h00);
  endtask
  task automatic t_mult(input logic [7:0] cmd);
    load(8'h02, 8'h02, 8'hfe, cmd);
    for (int n = 0; n < 500 && wr_vld !== 1'b1; n++) @(posedge clk_i);
    chk("lba", 28'h31234fe, lba);
    chk("no erase", cmd == 8'hcd, no_erase);
    if (cmd == 8'hc5) chk("word", 16'h5a00, wr_dat);
    wait_end();
    rd("status", 4'h6, 8'h8b, 8'h02);
    chk("irq clear", 32'h0, intrq_o);
    rd("count", 4'h1, 8'hff, 8'h00);
    rd("sector", 4'h2, 8'hff, 8'hff);
    rd("cyl hi", 4'h4, 8'hff, 8'h12);
  endtask
  task automatic t_dma(input logic bad);
    slow_q <= bad;
    fail_q <= bad;
    load(8'h00, bad ? 8'h03 : 8'h02, 8'h10, 8'hca);
    wait_end();
    rd("status", 4'h6, 8'h8b, bad ? 8'h03 : 8'h02);
    rd("count", 4'h1, 8'hff, bad ? 8'h03 : 8'h00);
    rd("sector", 4'h2, 8'hff, bad ? 8'h10 : 8'h11);
    if (bad) rd("error", 4'h8, 8'hff, 8'h40);
    slow_q <= 1'b0;
    fail_q <= 1'b0;
  endtask
  task automatic t_abort();
    logic [7:0] cfg [4];
    logic [7:0] cmd [4];
    cfg = '{8'h01, 8'h00, 8'h06, 8'h00};
    cmd = '{8'hca, 8'hc5, 8'hcd, 8'h30};
    for (int i = 0; i < 4; i++) begin
      load(cfg[i], 8'h01, 8'h00, cmd[i]);
      wait_end();
      rd("abort code", 4'h8, 8'hff, 8'h04);
      rd("abort status", 4'h6, 8'h89, 8'h01);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_mult(8'hc5);
    t_mult(8'hcd);
    t_dma(1'b0);
    t_dma(1'b1);
    t_abort();
    close_out();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    close_out();
  end
endmodule
